// *** rtl/reset_filter.sv ***
/*
 Reset pin filter: counts machine cycles in which the synchronised reset
 pin is seen high at the sampling phase, and asserts the internal reset
 once the minimum count is reached.
 Assumes a synchronised pin level and a one-cycle sample strobe.
*/
`timescale 1ns/100ps
`include "sysctl_regs.svh"

module reset_filter #(
	parameter int MIN_MCYCLES = `RESET_MIN_MCYCLES
) (
	input wire logic clock_i, // System clock
	input wire logic rst_n_i, // Synchronised reset
	input wire logic sample_i, // Sampling strobe, once per machine cycle
	input wire logic pin_i, // Synchronised reset pin level
	output logic reset_o // Filtered reset, level
);
	logic [3:0] count_r;
	logic [3:0] count_nxt;
	logic reset_r;
	logic reset_nxt;

	always_comb begin
		count_nxt = count_r;
		reset_nxt = reset_r;
		if (sample_i) begin
			if (!pin_i) begin
				count_nxt = 4'h0;
				reset_nxt = 1'b0;
			end else if (count_r >= 4'(MIN_MCYCLES - 1)) begin
				reset_nxt = 1'b1;
			end else begin
				count_nxt = count_r + 4'h1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_r <= 4'h0;
			reset_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			reset_r <= reset_nxt;
		end
	end

	assign reset_o = reset_r;
endmodule

// *** rtl/sysctl_pkg.sv ***
/*
 Types shared by the system control block.
 Assumes sysctl_regs.svh is on the include path.
*/
`include "sysctl_regs.svh"

package sysctl_pkg;
	typedef enum logic [2:0] {
		MODE_RUN = 3'b001,
		MODE_IDLE = 3'b010,
		MODE_PDOWN = 3'b100
	} power_mode_e;

	typedef struct packed {
		logic [7:0] port0;
		logic [7:0] port1;
		logic [7:0] port2;
		logic [7:0] port3;
		logic [7:0] stack_pointer;
		logic [7:0] power_control_register;
	} reset_state_s;

	typedef struct packed {
		logic idle;
		logic powerdown;
		logic cpu_clk_en;
		logic periph_clk_en;
		logic osc_en;
	} power_status_s;
endpackage

// *** rtl/sysctl_regs.svh ***
/*
 Reset, machine-cycle and power-mode constants for the system control block.
 Assumes inclusion from the package and the design modules only.
*/
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH

`define CLKS_PER_MCYCLE 12
`define PHASE_CNT_W 4
`define SAMPLE_PHASE 4'h9
`define RESET_MIN_MCYCLES 2
`define PORT_RESET_VAL 8'hFF
`define SP_RESET_VAL 8'h07
`define SFR_RESET_VAL 8'h00
`define POWER_CONTROL_REGISTER_IDLE_BIT 0
`define POWER_CONTROL_REGISTER_PD_BIT 1
`define POWER_CONTROL_REGISTER_POF_BIT 4
`define POWER_CONTROL_REGISTER_RESET_MASK 8'h10

`endif

// *** rtl/sysctl_top.sv ***
/*
 System control: reset pin filtering, register initialisation during reset
 and idle / power-down sequencing of the clock enables.
 Assumes clock_i is the oscillator clock; pins are asynchronous.
*/
`timescale 1ns/100ps
`include "sysctl_regs.svh"

// Summary of operation
// - Reset accepted only when pin high for two machine cycles; glitches ignored.
// - Reset pin sampled once per machine cycle at state five phase two.
// - During reset, port latches load all ones, stack pointer loads seven.
// - Other registers clear; serial buffer kept, power-on flag bit not cleared.
// - Idle request stops processor clock; peripheral and interrupt clocks keep running.
// - Idle is left on any interrupt or reset.
// - Power-down request stops all clocks and the oscillator.
// - Power-down left on hardware reset or enabled external interrupt zero or one.
// - Machine cycle is twelve oscillator clocks by default.
// - Power-on flag set on power-on reset; software may clear it.
// - Power-down request is bit 1, idle request bit 0 of power control.
module sysctl_top
	import sysctl_pkg::*;
#(
	parameter int CLKS_PER_MCYCLE = `CLKS_PER_MCYCLE
) (
	input wire logic clock_i, // Oscillator clock
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire logic power_on_i, // Power-on pulse from supply detector, same domain
	input wire logic reset_pin_i, // External reset pin, active high
	input wire logic ext_int_zero_n_i, // External interrupt zero pin, active low
	input wire logic ext_int_one_n_i, // External interrupt one pin, active low
	input wire logic ext_int_zero_en_i, // Interrupt zero enable
	input wire logic ext_int_one_en_i, // Interrupt one enable
	input wire logic irq_any_i, // Any pending interrupt, same domain
	input wire logic power_control_register_we_i, // Power control write strobe
	input wire logic [7:0] power_control_register_wdata_i, // Power control write data
	output sysctl_pkg::reset_state_s regs_o, // Register state
	output logic sfr_clear_o, // Clear other registers, keep serial buffer
	output logic sys_reset_o, // Filtered system reset
	output logic mcycle_strobe_o, // One pulse per machine cycle
	output sysctl_pkg::power_status_s status_o // Power mode and clock enables
);
	import sysctl_pkg::*;

	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [1:0] pin_sync_r;
	logic [1:0] external_interrupt_zero_sync_r;
	logic [1:0] external_interrupt_one_sync_r;
	logic [`PHASE_CNT_W-1:0] phase_r;
	logic [`PHASE_CNT_W-1:0] phase_nxt;
	logic sample;
	logic filt_reset;
	power_mode_e mode_r;
	power_mode_e mode_nxt;
	reset_state_s regs_r;
	reset_state_s regs_nxt;
	logic pd_wake;

	function automatic logic [`PHASE_CNT_W-1:0] phase_inc(input logic [`PHASE_CNT_W-1:0] p);
		if (p == `PHASE_CNT_W'(CLKS_PER_MCYCLE - 1))
			phase_inc = '0;
		else
			phase_inc = p + `PHASE_CNT_W'(1);
	endfunction

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// Pin synchronisers
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync_r <= 2'h0;
			external_interrupt_zero_sync_r <= 2'h3;
			external_interrupt_one_sync_r <= 2'h3;
		end else begin
			pin_sync_r <= {pin_sync_r[0], reset_pin_i};
			external_interrupt_zero_sync_r <= {external_interrupt_zero_sync_r[0], ext_int_zero_n_i};
			external_interrupt_one_sync_r <= {external_interrupt_one_sync_r[0], ext_int_one_n_i};
		end
	end

	// Machine cycle phase counter, runs unless oscillator halted
	always_comb begin
		phase_nxt = phase_r;
		if (mode_r != MODE_PDOWN)
			phase_nxt = phase_inc(phase_r);
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n)
			phase_r <= '0;
		else
			phase_r <= phase_nxt;
	end

	assign sample = (phase_r == `SAMPLE_PHASE) && (mode_r != MODE_PDOWN);
	assign mcycle_strobe_o = sample;

	reset_filter #(
		.MIN_MCYCLES(`RESET_MIN_MCYCLES)
	) u_reset_filter (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.sample_i(sample),
		.pin_i(pin_sync_r[1]),
		.reset_o(filt_reset)
	);

	// Power-down exit: oscillator stopped, so pin is seen directly
	assign pd_wake = (!external_interrupt_zero_sync_r[1] && ext_int_zero_en_i) || (!external_interrupt_one_sync_r[1] && ext_int_one_en_i)
		|| pin_sync_r[1];

	always_comb begin
		mode_nxt = mode_r;
		regs_nxt = regs_r;
		if (filt_reset || power_on_i) begin
			mode_nxt = MODE_RUN;
			regs_nxt.port0 = `PORT_RESET_VAL;
			regs_nxt.port1 = `PORT_RESET_VAL;
			regs_nxt.port2 = `PORT_RESET_VAL;
			regs_nxt.port3 = `PORT_RESET_VAL;
			regs_nxt.stack_pointer = `SP_RESET_VAL;
			regs_nxt.power_control_register = regs_r.power_control_register & `POWER_CONTROL_REGISTER_RESET_MASK;
			if (power_on_i)
				regs_nxt.power_control_register[`POWER_CONTROL_REGISTER_POF_BIT] = 1'b1;
		end else begin
			case (mode_r)
				MODE_RUN: begin
					if (power_control_register_we_i) begin
						regs_nxt.power_control_register = power_control_register_wdata_i;
						if (power_control_register_wdata_i[`POWER_CONTROL_REGISTER_PD_BIT])
							mode_nxt = MODE_PDOWN;
						else if (power_control_register_wdata_i[`POWER_CONTROL_REGISTER_IDLE_BIT])
							mode_nxt = MODE_IDLE;
					end
				end
				MODE_IDLE: begin
					if (irq_any_i) begin
						mode_nxt = MODE_RUN;
						regs_nxt.power_control_register[`POWER_CONTROL_REGISTER_IDLE_BIT] = 1'b0;
					end
				end
				MODE_PDOWN: begin
					if (pd_wake) begin
						mode_nxt = MODE_RUN;
						regs_nxt.power_control_register[`POWER_CONTROL_REGISTER_PD_BIT] = 1'b0;
						regs_nxt.power_control_register[`POWER_CONTROL_REGISTER_IDLE_BIT] = 1'b0;
					end
				end
				default: mode_nxt = MODE_RUN;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= MODE_RUN;
			regs_r <= {{4{`PORT_RESET_VAL}}, `SP_RESET_VAL, `SFR_RESET_VAL};
		end else begin
			mode_r <= mode_nxt;
			regs_r <= regs_nxt;
		end
	end

	assign regs_o = regs_r;
	assign sys_reset_o = filt_reset;
	assign sfr_clear_o = filt_reset || power_on_i;
	assign status_o.idle = (mode_r == MODE_IDLE);
	assign status_o.powerdown = (mode_r == MODE_PDOWN);
	assign status_o.cpu_clk_en = (mode_r == MODE_RUN);
	assign status_o.periph_clk_en = (mode_r != MODE_PDOWN);
	assign status_o.osc_en = (mode_r != MODE_PDOWN);
endmodule

// *** test/pin_source.sv ***
/*
 Model of the external reset source and interrupt pins.
 Assumes calls start just after a rising clock edge.
*/
`timescale 1ns/100ps
module pin_source (
	input wire logic clock_i, // Clock
	output logic reset_pin_o, // Reset pin, pulled low
	output logic int_n_o [2] // Interrupt pins, pulled high
);
	initial begin
		reset_pin_o = 1'b0;
		int_n_o = '{1'b1, 1'b1};
	end
	task automatic hold_reset(input int n);
		@(posedge clock_i) #1 reset_pin_o = 1'b1;
		repeat (n) @(posedge clock_i);
		#1 reset_pin_o = 1'b0;
	endtask
	task automatic pulse_int(input int k);
		@(posedge clock_i) #1 int_n_o[k] = 1'b0;
		repeat (6) @(posedge clock_i);
		#1 int_n_o[k] = 1'b1;
	endtask
endmodule

// *** test/sysctl_asserts.sv ***
/*
 Port checker for the system control block.
 Assumes binding to every sysctl_top instance.
*/
`timescale 1ns/100ps
module sysctl_asserts
	import sysctl_pkg::*;
(
	input wire logic clock_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic power_on_i, // Power-on
	input wire logic irq_any_i, // Interrupt
	input wire logic ext_int_zero_n_i, // Pin zero
	input wire logic ext_int_zero_en_i, // Enable zero
	input wire logic power_control_register_we_i, // Write
	input wire logic [7:0] power_control_register_wdata_i, // Data
	input sysctl_pkg::reset_state_s regs_o, // Registers
	input wire logic sfr_clear_o, // Clear
	input wire logic sys_reset_o, // Reset out
	input wire logic mcycle_strobe_o, // Strobe
	input sysctl_pkg::power_status_s status_o // Status
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	strobe_gap_a: assert property (mcycle_strobe_o |=> !mcycle_strobe_o [*8])
		else $error("strobe gap");
	ports_init_a: assert property (sys_reset_o ##1 sys_reset_o |-> regs_o.port0 == 8'hFF
		&& regs_o.port3 == 8'hFF && regs_o.stack_pointer == 8'h07) else $error("reset values");
	clear_out_a: assert property (sfr_clear_o == (sys_reset_o || power_on_i)) else $error("clear");
	pd_clocks_a: assert property (status_o.powerdown |-> !status_o.osc_en && !status_o.cpu_clk_en
		&& !status_o.periph_clk_en) else $error("pd clocks");
	idle_clocks_a: assert property (status_o.idle |-> !status_o.cpu_clk_en && status_o.periph_clk_en)
		else $error("idle clocks");
	idle_wake_a: assert property (status_o.idle && irq_any_i |-> ##[1:3] !status_o.idle)
		else $error("idle wake");
	pd_wake_a: assert property (status_o.powerdown && !ext_int_zero_n_i && ext_int_zero_en_i
		|-> ##[1:4] !status_o.powerdown) else $error("pd wake");
	pd_entry_a: assert property (!status_o.idle && !status_o.powerdown && !sfr_clear_o && power_control_register_we_i
		&& power_control_register_wdata_i[1] |=> status_o.powerdown) else $error("pd entry");
	wake_clear_a: assert property ($fell(status_o.powerdown) |-> ##[0:2]
		!regs_o.power_control_register[1]) else $error("wake clear");
endmodule
bind sysctl_top sysctl_asserts chk (.clock_i, .rst_n_i, .power_on_i, .irq_any_i, .ext_int_zero_n_i,
	.ext_int_zero_en_i, .power_control_register_we_i, .power_control_register_wdata_i, .regs_o, .sfr_clear_o, .sys_reset_o,
	.mcycle_strobe_o, .status_o);

// *** test/tb_top.sv ***
/*
 Self-checking bench of the system control block.
 Assumes the pin model drives the external pins.
*/
`timescale 1ns/100ps
`define CMP(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %0d exp %h seen %h", n, e, g); end end
module tb_top;
	import sysctl_pkg::*;
	typedef struct {int sel; logic [7:0] v;} note_s;
	logic clock_i = 1'b0, rst_n_i = 1'b0, power_on_i = 1'b0, irq_any_i = 1'b0, power_control_register_we_i = 1'b0;
	logic en0 = 1'b0, en1 = 1'b1, seen_rst = 1'b0, sys_reset_o, mcycle_strobe_o, sfr_clear_o;
	logic [7:0] power_control_register_wdata_i = 8'h00, r;
	logic reset_pin, int_n [2];
	logic [31:0] seed = 32'h4F8D586B;
	reset_state_s regs_o;
	power_status_s status_o;
	int num_errors = 0, checks = 0;
	note_s notes [$];
	event look;
	pin_source pins (.clock_i(clock_i), .reset_pin_o(reset_pin), .int_n_o(int_n));
	sysctl_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .power_on_i(power_on_i),
		.reset_pin_i(reset_pin), .ext_int_zero_n_i(int_n[0]), .ext_int_one_n_i(int_n[1]),
		.ext_int_zero_en_i(en0), .ext_int_one_en_i(en1), .irq_any_i(irq_any_i), .power_control_register_we_i(power_control_register_we_i),
		.power_control_register_wdata_i(power_control_register_wdata_i), .regs_o(regs_o), .sfr_clear_o(sfr_clear_o), .sys_reset_o(sys_reset_o),
		.mcycle_strobe_o(mcycle_strobe_o), .status_o(status_o));
	initial forever #2 clock_i = !clock_i;
	always @(posedge clock_i) if (sys_reset_o === 1'b1) seen_rst = 1'b1;
	function automatic logic [7:0] seen(input int s);
		logic [47:0] v;
		v = regs_o;
		return s < 6 ? v[8*s+:8] : s == 6 ? {3'h0, status_o} : s == 7 ? {7'h0, sys_reset_o} : {7'h0, seen_rst};
	endfunction
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s;
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic ex(input int s, input logic [7:0] v);
		notes.push_back('{s, v});
		-> look;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] d);
		power_control_register_we_i = 1'b1;
		power_control_register_wdata_i = d;
		step(1);
		power_control_register_we_i = 1'b0;
		step(1);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial forever begin
		note_s n;
		@(look);
		while (notes.size() != 0) begin
			n = notes.pop_front();
			`CMP(n.sel, n.v, seen(n.sel))
		end
	end
	initial begin
		step(4);
		rst_n_i = 1'b1;
		step(3);
		ex(0, 8'h00);
		ex(1, 8'h07);
		ex(5, 8'hFF);
		ex(6, 8'h07);
		$display("test reset done");
		power_on_i = 1'b1;
		step(1);
		power_on_i = 1'b0;
		step(1);
		ex(0, 8'h10);
		seed = xorshift(seed);
		r = seed[7:0] & 8'hDC;
		wr(r);
		ex(0, r);
		wr(r | 8'h01);
		ex(6, 8'h13);
		wr(8'h00);
		ex(0, r | 8'h01);
		irq_any_i = 1'b1;
		step(1);
		irq_any_i = 1'b0;
		step(3);
		ex(6, 8'h07);
		ex(0, r);
		$display("test idle done");
		wr(r | 8'h03);
		ex(6, 8'h08);
		pins.pulse_int(0);
		step(4);
		ex(6, 8'h08);
		pins.pulse_int(1);
		step(4);
		ex(6, 8'h07);
		ex(0, r);
		en0 = 1'b1;
		wr(r | 8'h02);
		pins.pulse_int(0);
		step(4);
		ex(6, 8'h07);
		$display("test powerdown done");
		seen_rst = 1'b0;
		pins.hold_reset(12);
		step(30);
		ex(8, 8'h00);
		pins.hold_reset(36);
		ex(7, 8'h01);
		ex(0, r & 8'h10);
		step(30);
		ex(7, 8'h00);
		$display("test pin done");
		conclude();
	end
	initial begin
		repeat (5000) @(posedge clock_i);
		num_errors++;
		conclude();
	end
endmodule
